/* hw/sdf_count.sv */
`timescale 1ns/1ps
module sdf_count
   import sdf_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH,
   parameter int CW = 7
) (
   input wire logic clock,
   input wire logic reset_n,
   sdf_occ_if.cnt occ
);
   typedef struct packed {
      logic [CW-1:0] count;
   } sdf_cnt_s;

   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [CW-1:0] ONE = CW'(1);

   sdf_cnt_s st;
   sdf_cnt_s next_st;

   // a push into a full store without a pop, or a pop from an empty one, is refused
   assign occ.overrun = occ.push && !occ.pop && (st.count == FULL);
   assign occ.underrun = occ.pop && (st.count == '0);
   assign occ.count = st.count;

   always_comb begin
      next_st = st;
      if (occ.flush) begin
         next_st.count = '0; // [R1]
      end else if (occ.push && !occ.overrun && !(occ.pop && !occ.underrun)) begin
         next_st.count = st.count + ONE; // [R11]
      end else if (occ.pop && !occ.underrun && !occ.push) begin
         next_st.count = st.count - ONE; // [R11]
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   a_count_bound: assert property (@(posedge clock) disable iff (!reset_n)
      st.count <= FULL) else $error("occupancy above depth"); // [R11]
endmodule // sdf_count

/* hw/sdf_fifo_status.sv */
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// (R1) writing one to fifo_flush empties the FIFO; the bit then clears itself
// (R2) overflow_underflow_error codes: 00 none, 01 fail, 10 fail in last transfer
// (R3) writing ones to the error field clears it; zeros leave it alone
// (R4) transmit mode: tx_space_available when 0..63 bytes; DMA request if enabled
// (R5) receive mode: rx_data_available when 1..64 bytes; DMA request if enabled
// (R6) tx_low_level reads one for 0..32 bytes, zero for 33..64
// (R7) tx_drained reads one only when the FIFO is empty
// (R8) rx_final_data sets on final data of the transfer, held until written one
// (R9) rx_at_capacity reads one only at 64 bytes
// (R10) rx_high_level reads one for 32..64 bytes, zero for 0..31
// (R11) byte_occupancy reports the current byte count in seven bits
// (R12) software may read an oversize final chunk, then clear error and flush
// (R13) transfer_direction picks none, busy, receive or transmit operation
// (R14) dma_request_enable selects polling or DMA requests
// (R15) level flags follow the occupancy within one cycle of push or pop
module sdf_fifo_status
   import sdf_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [31:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData,
   input wire logic cardPush,
   input wire logic cardPop,
   input wire logic finalData,
   input wire logic lastTransfer,
   output logic fifoFlushOut,
   output logic dmaRequest,
   output logic irq
);
   localparam int CW = $clog2(DEPTH + 1);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      sdf_phase_e phase;
      logic flushOut;
      logic [1:0] err;
      logic rxFinal;
      sdf_dir_e dir;
      logic dmaEn;
      logic [INT_W-1:0] intStatus;
      logic [INT_W-1:0] intMask;
      logic drainedPrev;
      logic fullPrev;
      logic [31:0] rdData;
      logic dmaReq;
      logic irq;
   } sdf_top_s;

   localparam sdf_top_s ST_RESET = '{
      phase: PH_RUN,
      flushOut: 1'b0,
      err: ERR_NONE,
      rxFinal: 1'b0,
      dir: DIR_NONE,
      dmaEn: 1'b0,
      intStatus: '0,
      intMask: '0,
      drainedPrev: 1'b1, // an empty store after reset must not look like a fresh drain edge
      fullPrev: 1'b0,
      rdData: REG_RESET,
      dmaReq: 1'b0,
      irq: 1'b0
   };

   sdf_top_s st;
   sdf_top_s next_st;

   sdf_occ_if #(.CW(CW)) occ ();

   function automatic logic hit(input logic [31:0] addr, input logic [31:0] target);
      hit = (addr == target);
   endfunction

   // ----------------------------------------------------------------
   // occupancy counter and level decode
   // ----------------------------------------------------------------
   sdf_count #(.DEPTH(DEPTH), .CW(CW)) u_count (
      .clock(clock),
      .reset_n(reset_n),
      .occ(occ)
   );

   sdf_levels #(.DEPTH(DEPTH), .CW(CW)) u_levels (
      .occ(occ)
   );

   // strobes seen during the flush cycle are dropped with the data
   assign occ.push = cardPush && !st.flushOut;
   assign occ.pop = cardPop && !st.flushOut;
   assign occ.flush = st.flushOut; // [R1]
   assign occ.dir = st.dir; // [R13]

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic statusWr;
   logic controlWr;
   logic maskWr;
   logic flushWr;
   logic intRd;
   logic failEvent;
   logic dmaCause;
   logic [31:0] statusWord;
   logic [31:0] readWord;
   logic [INT_W-1:0] events;

   assign statusWr = regWrite && hit(regAddr, FIFO_STATUS_ADDR);
   assign controlWr = regWrite && hit(regAddr, CONTROL_ADDR);
   assign maskWr = regWrite && hit(regAddr, INT_MASK_ADDR);
   assign flushWr = statusWr && regWrData[FLUSH_BIT];
   assign intRd = regRead && hit(regAddr, INT_STATUS_ADDR);
   assign failEvent = occ.overrun || occ.underrun;
   assign dmaCause = st.dmaEn && (occ.txSpace || occ.rxAvail); // [R4] [R5] [R14]

   always_comb begin
      statusWord = REG_RESET;
      statusWord[FLUSH_BIT] = (st.phase == PH_FLUSH); // [R1]
      statusWord[ERR_HI:ERR_LO] = st.err; // [R2]
      statusWord[TX_SPACE_BIT] = occ.txSpace; // [R4]
      statusWord[RX_AVAIL_BIT] = occ.rxAvail; // [R5]
      statusWord[TX_LOW_BIT] = occ.txLow; // [R6]
      statusWord[TX_DRAINED_BIT] = occ.txDrained; // [R7]
      statusWord[RX_FINAL_BIT] = st.rxFinal; // [R8]
      statusWord[RX_FULL_BIT] = occ.rxFull; // [R9]
      statusWord[RX_HIGH_BIT] = occ.rxHigh; // [R10]
      statusWord[OCC_HI:0] = 7'(occ.count); // [R11]
   end

   // unmapped addresses read as zero
   always_comb begin
      readWord = REG_RESET;
      if (hit(regAddr, FIFO_STATUS_ADDR)) begin
         readWord = statusWord;
      end else if (hit(regAddr, CONTROL_ADDR)) begin
         readWord[DMA_EN_BIT] = st.dmaEn;
         readWord[DIR_HI:DIR_LO] = st.dir;
      end else if (hit(regAddr, INT_STATUS_ADDR)) begin
         readWord[INT_W-1:0] = st.intStatus;
      end else if (hit(regAddr, INT_MASK_ADDR)) begin
         readWord[INT_W-1:0] = st.intMask;
      end
   end

   // edges, not levels, so a drained or full FIFO interrupts once
   always_comb begin
      events = '0;
      events[INT_ERR] = failEvent;
      events[INT_FINAL] = finalData;
      events[INT_DRAIN] = occ.txDrained && !st.drainedPrev;
      events[INT_FULL] = occ.rxFull && !st.fullPrev;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.flushOut = 1'b0;
      next_st.phase = PH_RUN;
      case (st.phase)
         PH_RUN: begin
            if (flushWr) begin
               next_st.phase = PH_FLUSH; // [R1]
               next_st.flushOut = 1'b1; // [R1]
            end
         end
         PH_FLUSH: begin
            // back-to-back flush writes simply flush again
            if (flushWr) begin
               next_st.phase = PH_FLUSH;
               next_st.flushOut = 1'b1;
            end
         end
         default: begin
            next_st.phase = PH_RUN;
         end
      endcase

      if (statusWr) begin
         next_st.err = st.err & ~regWrData[ERR_HI:ERR_LO]; // [R3]
         if (regWrData[RX_FINAL_BIT]) begin
            next_st.rxFinal = 1'b0; // [R8]
         end
      end
      // a new fault wins over a clear in the same cycle
      if (failEvent) begin
         next_st.err = lastTransfer ? ERR_LAST : ERR_FAIL; // [R2]
      end
      if (finalData) begin
         next_st.rxFinal = 1'b1; // [R8]
      end

      if (controlWr) begin
         next_st.dmaEn = regWrData[DMA_EN_BIT]; // [R14]
         next_st.dir = sdf_dir_e'(regWrData[DIR_HI:DIR_LO]); // [R13]
      end
      if (maskWr) begin
         next_st.intMask = regWrData[INT_W-1:0];
      end

      next_st.intStatus = (intRd ? '0 : st.intStatus) | events;
      next_st.drainedPrev = occ.txDrained;
      next_st.fullPrev = occ.rxFull;
      next_st.rdData = regRead ? readWord : REG_RESET;
      next_st.dmaReq = dmaCause; // [R4] [R5] [R14]
      next_st.irq = |(next_st.intStatus & next_st.intMask);
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st <= ST_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign regRdData = st.rdData;
   assign fifoFlushOut = st.flushOut;
   assign dmaRequest = st.dmaReq;
   assign irq = st.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   logic statusRd;
   assign statusRd = regRead && hit(regAddr, FIFO_STATUS_ADDR);

   a_flush_empties: assert property ( // [R1]
      flushWr |=> fifoFlushOut ##1 (occ.count == '0))
      else $error("flush did not empty the fifo");

   a_flush_self_clear: assert property ( // [R1]
      fifoFlushOut && !$past(flushWr) |-> 1'b0)
      else $error("flush pulse without a flush write");

   a_err_no_code3: assert property ( // [R2]
      st.err != 2'h3)
      else $error("reserved error code recorded");

   a_err_fail_code: assert property ( // [R2]
      failEvent |=> (st.err == ($past(lastTransfer) ? ERR_LAST : ERR_FAIL)))
      else $error("error code does not match fault");

   a_err_w1c_clear: assert property ( // [R3]
      statusWr && (regWrData[ERR_HI:ERR_LO] == 2'h3) && !failEvent |=> st.err == ERR_NONE)
      else $error("error field not cleared by ones");

   a_err_zero_keep: assert property ( // [R3]
      statusWr && (regWrData[ERR_HI:ERR_LO] == 2'h0) && !failEvent |=> $stable(st.err))
      else $error("error field changed by zeros");

   a_dma_follows: assert property ( // [R4] [R5] [R14]
      ##1 (dmaRequest == $past(dmaCause)))
      else $error("dma request does not track availability");

   a_tx_space_read: assert property ( // [R4] [R13]
      statusRd |=> regRdData[TX_SPACE_BIT]
         == ($past(st.dir == DIR_TX) && ($past(occ.count) < CW'(DEPTH))))
      else $error("tx space flag wrong");

   a_rx_avail_read: assert property ( // [R5] [R13]
      statusRd |=> regRdData[RX_AVAIL_BIT]
         == ($past(st.dir == DIR_RX) && ($past(occ.count) != '0)))
      else $error("rx available flag wrong");

   a_tx_low_read: assert property ( // [R6]
      statusRd |=> regRdData[TX_LOW_BIT] == ($past(occ.count) <= CW'(TX_LOW_MAX)))
      else $error("tx low flag wrong");

   a_drained_read: assert property ( // [R7] [R9] [R10]
      statusRd |=> regRdData[TX_DRAINED_BIT] == ($past(occ.count) == '0)
         && regRdData[RX_FULL_BIT] == ($past(occ.count) == CW'(DEPTH))
         && regRdData[RX_HIGH_BIT] == ($past(occ.count) >= CW'(RX_HIGH_MIN)))
      else $error("drained, full or high flag wrong");

   a_final_sticky: assert property ( // [R8]
      st.rxFinal && !(statusWr && regWrData[RX_FINAL_BIT]) |=> st.rxFinal)
      else $error("final data flag lost");

   a_occ_read: assert property ( // [R11]
      statusRd |=> regRdData[OCC_HI:0] == 7'($past(occ.count)))
      else $error("occupancy read wrong");

   a_level_track: assert property ( // [R15]
      $past(cardPush) && !$past(cardPop) && !$past(fifoFlushOut) && !$past(occ.overrun)
         |-> occ.count == $past(occ.count) + CW'(1))
      else $error("count did not follow a push");

   a_count_pop: assert property ( // [R15]
      $past(cardPop) && !$past(cardPush) && !$past(fifoFlushOut) && !$past(occ.underrun)
         |-> occ.count == $past(occ.count) - CW'(1))
      else $error("count did not follow a pop");

   a_flush_bit_read: assert property ( // [R1]
      statusRd |=> regRdData[FLUSH_BIT] == $past(fifoFlushOut))
      else $error("flush bit read wrong");

   a_err_hold: assert property ( // [R2] [R3]
      !statusWr && !failEvent |=> $stable(st.err))
      else $error("error field moved without cause");

   a_final_set: assert property ( // [R8]
      finalData |=> st.rxFinal)
      else $error("final data flag not set");

   a_final_clear: assert property ( // [R8]
      statusWr && regWrData[RX_FINAL_BIT] && !finalData |=> !st.rxFinal)
      else $error("final data flag not cleared by one");

   a_dma_gate: assert property ( // [R14]
      !st.dmaEn |=> !dmaRequest)
      else $error("dma request while polling");

   a_space_gated: assert property ( // [R4] [R13]
      st.dir != DIR_TX |-> !occ.txSpace)
      else $error("tx space outside transmit");

   a_avail_gated: assert property ( // [R5] [R13]
      st.dir != DIR_RX |-> !occ.rxAvail)
      else $error("rx available outside receive");

   a_overrun_keep: assert property ( // [R11]
      occ.overrun && !occ.flush |=> occ.count == CW'(DEPTH))
      else $error("refused push moved the count");

   a_underrun_keep: assert property ( // [R11]
      occ.underrun && !occ.push && !occ.flush |=> occ.count == '0)
      else $error("refused pop moved the count");

   a_drain_edge: assert property ( // [R7]
      $rose(st.intStatus[INT_DRAIN]) |-> ($past(occ.count) == '0) && ($past(occ.count, 2) != '0))
      else $error("drain event without a real drain");

   c_tx_full: cover property (st.dir == DIR_TX && !occ.txSpace);
   c_rx_last_fail: cover property (failEvent && lastTransfer);
   c_flush_burst: cover property (flushWr ##1 flushWr);
   c_irq_raised: cover property (!irq ##1 irq);
   c_dma_rx: cover property (st.dmaEn && occ.rxAvail);
endmodule // sdf_fifo_status

/* hw/sdf_levels.sv */
`timescale 1ns/1ps
module sdf_levels
   import sdf_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH,
   parameter int CW = 7
) (
   sdf_occ_if.lvl occ
);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [CW-1:0] LOW_MAX = CW'(TX_LOW_MAX);
   localparam logic [CW-1:0] HIGH_MIN = CW'(RX_HIGH_MIN);

   // flags follow the live count, so they move in the same cycle as it
   always_comb begin
      occ.txSpace = (occ.dir == DIR_TX) && (occ.count < FULL); // [R4] [R13] [R15]
      occ.rxAvail = (occ.dir == DIR_RX) && (occ.count != '0); // [R5] [R13] [R15]
      occ.txLow = (occ.count <= LOW_MAX); // [R6]
      occ.txDrained = (occ.count == '0); // [R7]
      occ.rxFull = (occ.count == FULL); // [R9]
      occ.rxHigh = (occ.count >= HIGH_MIN); // [R10]
   end
endmodule // sdf_levels

/* hw/sdf_occ_if.sv */
`timescale 1ns/1ps
interface sdf_occ_if
   import sdf_pkg::*;
#(
   parameter int CW = 7
);
   logic push;
   logic pop;
   logic flush;
   logic overrun;
   logic underrun;
   logic [CW-1:0] count;
   sdf_dir_e dir;
   logic txSpace;
   logic rxAvail;
   logic txLow;
   logic txDrained;
   logic rxFull;
   logic rxHigh;
   modport cnt(input push, pop, flush, output count, overrun, underrun);
   modport lvl(input count, dir, output txSpace, rxAvail, txLow, txDrained, rxFull, rxHigh);
   modport top(output push, pop, flush, dir,
      input count, overrun, underrun, txSpace, rxAvail, txLow, txDrained, rxFull, rxHigh);
endinterface

/* hw/sdf_pkg.sv */
package sdf_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [31:0] FIFO_STATUS_ADDR = 32'h4600_0038;
   localparam logic [31:0] CONTROL_ADDR = 32'h4600_0050;
   localparam logic [31:0] INT_STATUS_ADDR = 32'h4600_0054;
   localparam logic [31:0] INT_MASK_ADDR = 32'h4600_0058;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   // ----------------------------------------------------------------
   // fifo_status fields
   // ----------------------------------------------------------------
   localparam int FLUSH_BIT = 16;
   localparam int ERR_HI = 15;
   localparam int ERR_LO = 14;
   localparam int TX_SPACE_BIT = 13;
   localparam int RX_AVAIL_BIT = 12;
   localparam int TX_LOW_BIT = 11;
   localparam int TX_DRAINED_BIT = 10;
   localparam int RX_FINAL_BIT = 9;
   localparam int RX_FULL_BIT = 8;
   localparam int RX_HIGH_BIT = 7;
   localparam int OCC_HI = 6;
   // ----------------------------------------------------------------
   // control and interrupt fields
   // ----------------------------------------------------------------
   localparam int DMA_EN_BIT = 15;
   localparam int DIR_HI = 13;
   localparam int DIR_LO = 12;
   localparam int INT_W = 4;
   localparam int INT_ERR = 0;
   localparam int INT_FINAL = 1;
   localparam int INT_DRAIN = 2;
   localparam int INT_FULL = 3;
   // ----------------------------------------------------------------
   // sizes and codes
   // ----------------------------------------------------------------
   localparam int FIFO_DEPTH = 64;
   localparam int TX_LOW_MAX = 32;
   localparam int RX_HIGH_MIN = 32;
   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam logic [1:0] ERR_FAIL = 2'h1;
   localparam logic [1:0] ERR_LAST = 2'h2;
   typedef enum logic [1:0] {
      DIR_NONE = 2'h0, DIR_BUSY = 2'h1, DIR_RX = 2'h2, DIR_TX = 2'h3
   } sdf_dir_e;
   typedef enum logic [1:0] {PH_RUN = 2'b01, PH_FLUSH = 2'b10} sdf_phase_e;
endpackage

/* tb/sd_host_fifo_status_tb.sv */
`timescale 1ns/1ps
module sd_host_fifo_status_tb;
   import sdf_pkg::*;
   logic clock;
   logic reset_n;
   logic [31:0] regAddr;
   logic [31:0] regWrData;
   logic [31:0] regRdData;
   logic [31:0] rdv;
   logic regWrite;
   logic regRead;
   logic pushReq;
   logic popReq;
   logic finalReq;
   logic lastReq;
   logic cardPush;
   logic cardPop;
   logic finalData;
   logic lastTransfer;
   logic fifoFlushOut;
   logic dmaRequest;
   logic irq;
   logic [1:0] ex;
   logic fi;
   logic dm;
   logic [31:0] ew;
   int miscompares;
   int n_tests;
   int occ;
   int tgt[13];
   sdf_fifo_status #(.DEPTH(FIFO_DEPTH)) u_dut (.clock(clock), .reset_n(reset_n),
      .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .cardPush(cardPush), .cardPop(cardPop), .finalData(finalData),
      .lastTransfer(lastTransfer), .fifoFlushOut(fifoFlushOut), .dmaRequest(dmaRequest),
      .irq(irq));
   sdf_card_model u_card (.clock(clock), .reset_n(reset_n), .pushReq(pushReq),
      .popReq(popReq), .finalReq(finalReq), .lastReq(lastReq), .cardPush(cardPush),
      .cardPop(cardPop), .finalData(finalData), .lastTransfer(lastTransfer));
   // ---------------------------------------------------------------
   // expectation and bus helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] exp_st(int c, logic [1:0] d, logic [1:0] e, logic f);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[6:0] = c[6:0];
      w[7] = (c >= 32);
      w[8] = (c == 64);
      w[9] = f;
      w[10] = (c == 0);
      w[11] = (c <= 32);
      w[12] = (d == DIR_RX) && (c >= 1);
      w[13] = (d == DIR_TX) && (c <= 63);
      w[15:14] = e;
      return w;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      @(negedge clock);
      d = regRdData;
   endtask
   task automatic st(input logic [1:0] d);
      rd(FIFO_STATUS_ADDR, rdv);
      chk("fifo_status", exp_st(occ, d, ex, fi), rdv);
   endtask
   task automatic move(input int t);
      while (occ != t) begin
         @(posedge clock);
         pushReq <= (occ < t);
         popReq <= (occ > t);
         occ += (occ < t) ? 1 : -1;
      end
      @(posedge clock);
      pushReq <= 1'b0;
      popReq <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   // one refused strobe: the count must not move
   task automatic bad(input logic p);
      @(posedge clock);
      pushReq <= p;
      popReq <= !p;
      @(posedge clock);
      pushReq <= 1'b0;
      popReq <= 1'b0;
      repeat (3) @(posedge clock);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // clock, reset and watchdog
   // ---------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      repeat (100000) @(posedge clock);
      miscompares++;
      final_report();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      regAddr = 32'h0000_0000;
      regWrData = 32'h0000_0000;
      regWrite = 1'b0;
      regRead = 1'b0;
      pushReq = 1'b0;
      popReq = 1'b0;
      finalReq = 1'b0;
      lastReq = 1'b0;
      occ = 0;
      ex = ERR_NONE;
      fi = 1'b0;
      void'($urandom(35910));
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      rd(FIFO_STATUS_ADDR, rdv);
      chk("status reset", REG_RESET | 32'h0000_0C00, rdv);
      rd(CONTROL_ADDR, rdv);
      chk("control reset", REG_RESET, rdv);
      rd(INT_MASK_ADDR, rdv);
      chk("mask reset", REG_RESET, rdv);
      rd(32'h4600_0060, rdv);
      chk("unmapped", 32'h0000_0000, rdv);
      $display("test reset done");
      tgt = '{0, 1, 31, 32, 33, 63, 64, 0, 0, 0, 0, 0, 0};
      for (int i = 7; i < 13; i++) tgt[i] = $urandom % 65;
      foreach (tgt[i]) begin
         move(tgt[i]);
         for (int d = 0; d < 4; d++) begin
            dm = $urandom % 2;
            wr(CONTROL_ADDR, {16'h0000, dm, 1'b0, d[1:0], 12'h000});
            st(d[1:0]);
            ew = exp_st(occ, d[1:0], ex, fi);
            chk("dmaRequest", {31'h0, dm & (ew[12] | ew[13])}, {31'h0, dmaRequest});
         end
      end
      $display("test levels done");
      // busy-check direction: neither availability flag may show from here on
      wr(CONTROL_ADDR, 32'h0000_1000);
      move(64);
      rd(INT_STATUS_ADDR, rdv);
      wr(INT_MASK_ADDR, 32'h0000_0001);
      rd(INT_MASK_ADDR, rdv);
      chk("mask", 32'h0000_0001, rdv);
      bad(1'b1);
      ex = ERR_FAIL;
      chk("irq set", 32'h1, {31'h0, irq});
      st(DIR_BUSY);
      rd(INT_STATUS_ADDR, rdv);
      chk("int status", 32'h0000_0001, rdv);
      repeat (2) @(negedge clock);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wr(INT_MASK_ADDR, 32'h0000_0000);
      bad(1'b1);
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(FIFO_STATUS_ADDR, 32'h0000_0000);
      st(DIR_BUSY);
      wr(FIFO_STATUS_ADDR, 32'h0000_C000);
      ex = ERR_NONE;
      st(DIR_BUSY);
      move(0);
      lastReq <= 1'b1;
      bad(1'b0);
      ex = ERR_LAST;
      st(DIR_BUSY);
      lastReq <= 1'b0;
      wr(FIFO_STATUS_ADDR, 32'h0000_C000);
      ex = ERR_NONE;
      st(DIR_BUSY);
      $display("test errors done");
      move(40);
      @(posedge clock);
      finalReq <= 1'b1;
      @(posedge clock);
      finalReq <= 1'b0;
      fi = 1'b1;
      repeat (3) @(posedge clock);
      st(DIR_BUSY);
      st(DIR_BUSY);
      wr(FIFO_STATUS_ADDR, 32'h0001_0000);
      @(negedge clock);
      chk("flush pulse", 32'h1, {31'h0, fifoFlushOut});
      @(negedge clock);
      chk("flush end", 32'h0, {31'h0, fifoFlushOut});
      occ = 0;
      st(DIR_BUSY);
      wr(FIFO_STATUS_ADDR, 32'h0000_0200);
      fi = 1'b0;
      st(DIR_BUSY);
      $display("test flush and final done");
      final_report();
   end
endmodule // sd_host_fifo_status_tb

/* tb/sdf_card_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// card data path and dma side: turns bench requests into byte strobes
// ---------------------------------------------------------------
// strobes are registered so that they leave on a clock edge, just as the
// real data path would launch them; a held request gives back-to-back bytes
module sdf_card_model (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic pushReq,
   input wire logic popReq,
   input wire logic finalReq,
   input wire logic lastReq,
   output logic cardPush,
   output logic cardPop,
   output logic finalData,
   output logic lastTransfer
);
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cardPush <= 1'b0;
         cardPop <= 1'b0;
         finalData <= 1'b0;
         lastTransfer <= 1'b0;
      end else begin
         cardPush <= pushReq;
         cardPop <= popReq;
         finalData <= finalReq;
         lastTransfer <= lastReq;
      end
   end
endmodule // sdf_card_model
